// *** rba_top.sv ***
// rba_top: receive byte assembler with interrupt enables, reached over
// a classic Wishbone slave with 8-bit registers in the low data lane.
// assumes all inputs synchronous to mclk_i.
//
// Overview of operation
// - control bit 3 selects byte mode
// - byte mode passes whole bytes via registers
// - gap field sets empty bit times before end
// - gap counting starts after a valid bit
// - end of frame loads gathered bits
// - gap zero ends at first empty bit
// - enable bit 7 gates channel B underflow
// - enable bit 6 gates channel B overflow
// - enable bit 5 gates channel B end
// - status read clears pending end of frame
// - enable bit 4 gates channel B full
// - bits 3..0 same for channel A
// - flow flag joins overflow and underflow
`timescale 1ns/10ps
module rba_top #(
    parameter int ADR_W = 8
) (
    input wire logic mclk_i, // 250 MHz core clock
    input wire logic reset_i, // synchronous reset, high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [ADR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // wishbone ack
    input wire logic rx_enable_i, // receiver in receive mode
    input wire logic bit_tick_i, // one pulse per bit time
    input rba_pkg::rba_rx_bit_t rx_a_i, // channel A bit
    input rba_pkg::rba_rx_bit_t rx_b_i, // channel B bit
    output logic [7:0] tx_byte_o, // byte to transmit
    output logic tx_byte_valid_o, // pulse with tx byte
    output logic serial_data_pin_o, // bit-serial data
    output logic serial_data_valid_pin_o, // bit-serial valid
    output logic irq_o // interrupt, high
);
    import rba_pkg::*;

    generate
        if (ADR_W < 8) begin : g_chk
            $error("rba_top: ADR_W must be at least 8");
        end
    endgenerate

    rba_state_t s;
    rba_state_t next_s;
    rba_asm_out_t asm_out [RBA_CHANNELS];
    rba_rx_bit_t rx_bits [RBA_CHANNELS];
    logic asm_en;

    // register index of a channel's data register
    function automatic logic [5:0] data_idx(input int ch);
        data_idx = (ch == 0) ? RBA_IDX_DATA_A : RBA_IDX_DATA_B;
    endfunction

    // one status nibble from pending events and data state
    function automatic logic [3:0] stat_nib(input logic [3:0] pend,
                                            input logic valid);
        logic [3:0] n;
        n = 4'h0;
        n[RBA_ST_FULL] = pend[RBA_EV_FULL];
        n[RBA_ST_EOF] = pend[RBA_EV_EOF];
        n[RBA_ST_FLOW] = pend[RBA_EV_OVF] | pend[RBA_EV_UNF];
        n[RBA_ST_VALID] = valid;
        stat_nib = n;
    endfunction

    assign rx_bits[0] = rx_a_i;
    assign rx_bits[1] = rx_b_i;
    assign asm_en = s.ctl[RBA_CTL_BYTE_MODE] & rx_enable_i;

    for (genvar g = 0; g < RBA_CHANNELS; g++) begin : g_ch
        rba_assembler u_asm (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .enable_i(asm_en),
            .gap_len_i(s.ctl[RBA_CTL_GAP_LSB +: 3]),
            .bit_tick_i(bit_tick_i),
            .rx_i(rx_bits[g]),
            .out_o(asm_out[g])
        );
    end

    logic req;
    logic wr;
    logic rd;
    logic lane0;
    logic [5:0] idx;
    logic [7:0] wdat;
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic [7:0] rval;
    logic rd_data;

    always_comb begin
        next_s = s;
        req = wb_cyc_i & wb_stb_i & ~s.ack;
        wr = req & wb_we_i;
        rd = req & ~wb_we_i;
        lane0 = wb_sel_i[0];
        idx = wb_adr_i[7:2];
        wdat = wb_dat_i[7:0];
        set_ev = 8'h00;
        clr_ev = 8'h00;
        rval = 8'h00;
        rd_data = 1'b0;

        next_s.ack = req;
        next_s.tx_valid = 1'b0;

        // read value, taken before this cycle's side effects
        case (idx)
            RBA_IDX_CTL: begin
                rval = s.ctl;
            end
            RBA_IDX_EN: begin
                rval = s.en;
            end
            RBA_IDX_STAT: begin
                rval = {stat_nib(s.pend[7:4], s.all_valid[1]),
                        stat_nib(s.pend[3:0], s.all_valid[0])};
            end
            RBA_IDX_DATA_A: begin
                rval = s.data[0];
            end
            RBA_IDX_DATA_B: begin
                rval = s.data[1];
            end
            RBA_IDX_TX: begin
                rval = s.tx;
            end
            RBA_IDX_PEND: begin
                rval = s.pend;
            end
            default: begin
                rval = 8'h00;
            end
        endcase
        if (rd) begin
            next_s.rdat = {24'h000000, rval};
        end

        // register writes
        if (wr && lane0) begin
            case (idx)
                RBA_IDX_CTL: begin
                    // reserved bits always stored as zero
                    next_s.ctl = wdat & RBA_CTL_WMASK;
                end
                RBA_IDX_EN: begin
                    next_s.en = wdat;
                end
                RBA_IDX_TX: begin
                    if (s.ctl[RBA_CTL_BYTE_MODE]) begin
                        next_s.tx = wdat;
                        next_s.tx_valid = 1'b1;
                    end
                end
                RBA_IDX_PEND: begin
                    clr_ev = wdat;
                end
                default: begin
                end
            endcase
        end

        // status read clears end, flow and full events
        if (rd && idx == RBA_IDX_STAT) begin
            clr_ev = 8'hff;
        end

        // per channel data register and its events
        for (int ch = 0; ch < RBA_CHANNELS; ch++) begin
            rd_data = rd && (idx == data_idx(ch));
            if (asm_out[ch].load) begin
                set_ev[ch*RBA_NIB + RBA_EV_FULL] = 1'b1;
                if (s.full[ch] && !rd_data) begin
                    set_ev[ch*RBA_NIB + RBA_EV_OVF] = 1'b1;
                end
                next_s.data[ch] = asm_out[ch].data;
                next_s.all_valid[ch] = asm_out[ch].all_valid;
                next_s.full[ch] = 1'b1;
            end else if (rd_data) begin
                next_s.full[ch] = 1'b0;
            end
            if (rd_data && !s.full[ch]) begin
                set_ev[ch*RBA_NIB + RBA_EV_UNF] = 1'b1;
            end
            if (asm_out[ch].eof) begin
                set_ev[ch*RBA_NIB + RBA_EV_EOF] = 1'b1;
            end
        end

        // a new event wins over a clear in the same cycle
        next_s.pend = (s.pend & ~clr_ev) | set_ev;

        next_s.irq = |(next_s.pend & next_s.en);

        // bit-serial path follows channel A
        if (!s.ctl[RBA_CTL_BYTE_MODE]) begin
            next_s.sdata = rx_a_i.value;
            next_s.svalid = bit_tick_i & rx_a_i.valid & rx_enable_i;
        end else begin
            next_s.sdata = 1'b0;
            next_s.svalid = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s <= '{ctl: RBA_CTL_RESET, en: RBA_EN_RESET,
                   pend: RBA_PEND_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.rdat;
    assign wb_ack_o = s.ack;
    assign tx_byte_o = s.tx;
    assign tx_byte_valid_o = s.tx_valid;
    assign serial_data_pin_o = s.sdata;
    assign serial_data_valid_pin_o = s.svalid;
    assign irq_o = s.irq;
endmodule

// *** rba_pkg.sv ***
// rba_pkg: register indices, field layout, reset values and carriers
// for the receive byte assembler; shared by the top and the assembler.
package rba_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] RBA_IDX_CTL = 6'h06;
    localparam logic [5:0] RBA_IDX_EN = 6'h07;
    localparam logic [5:0] RBA_IDX_STAT = 6'h08;
    localparam logic [5:0] RBA_IDX_DATA_A = 6'h09;
    localparam logic [5:0] RBA_IDX_TX = 6'h0a;
    localparam logic [5:0] RBA_IDX_DATA_B = 6'h0b;
    localparam logic [5:0] RBA_IDX_PEND = 6'h0c;

    // serializer_control fields
    localparam int RBA_CTL_BYTE_MODE = 3;
    localparam int RBA_CTL_GAP_LSB = 0;
    localparam logic [7:0] RBA_CTL_WMASK = 8'h0f;
    localparam logic [7:0] RBA_CTL_RESET = 8'h03;
    localparam logic [7:0] RBA_EN_RESET = 8'h00;
    localparam logic [7:0] RBA_PEND_RESET = 8'h00;

    // event bits per channel nibble: enable and pending share it
    localparam int RBA_EV_FULL = 0;
    localparam int RBA_EV_EOF = 1;
    localparam int RBA_EV_OVF = 2;
    localparam int RBA_EV_UNF = 3;
    // status bits per channel nibble
    localparam int RBA_ST_FULL = 0;
    localparam int RBA_ST_EOF = 1;
    localparam int RBA_ST_FLOW = 2;
    localparam int RBA_ST_VALID = 3;
    localparam int RBA_NIB = 4;

    localparam int RBA_CHANNELS = 2;
    localparam logic [3:0] RBA_CNT_LAST = 4'h7;

    typedef struct packed {
        logic valid;
        logic value;
    } rba_rx_bit_t;

    typedef struct packed {
        logic load;
        logic eof;
        logic all_valid;
        logic [7:0] data;
    } rba_asm_out_t;

    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] count;
        logic seen;
        logic [3:0] gap;
        rba_asm_out_t out;
    } rba_asm_state_t;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] en;
        logic [7:0] pend;
        logic [1:0][7:0] data;
        logic [1:0] full;
        logic [1:0] all_valid;
        logic [7:0] tx;
        logic tx_valid;
        logic ack;
        logic [31:0] rdat;
        logic irq;
        logic sdata;
        logic svalid;
    } rba_state_t;
endpackage

// *** rba_assembler.sv ***
// rba_assembler: gathers received bits of one channel into bytes and
// detects end of frame from a count of empty bit times.
// assumes bit_tick_i is a one-cycle pulse per bit time.
`timescale 1ns/10ps
module rba_assembler (
    input wire logic mclk_i, // core clock
    input wire logic reset_i, // synchronous reset, high
    input wire logic enable_i, // byte mode and receive on
    input wire logic [2:0] gap_len_i, // frame-gap length
    input wire logic bit_tick_i, // one pulse per bit time
    input rba_pkg::rba_rx_bit_t rx_i, // correlated bit
    output rba_pkg::rba_asm_out_t out_o // load and end of frame
);
    import rba_pkg::*;

    rba_asm_state_t s;
    rba_asm_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.out.load = 1'b0;
        next_s.out.eof = 1'b0;
        if (!enable_i) begin
            next_s.shift = 8'h00;
            next_s.count = 4'h0;
            next_s.seen = 1'b0;
            next_s.gap = 4'h0;
        end else if (bit_tick_i) begin
            if (rx_i.valid) begin
                next_s.shift = {s.shift[6:0], rx_i.value};
                next_s.count = s.count + 4'h1;
                next_s.seen = 1'b1;
                next_s.gap = 4'h0;
                if (s.count == RBA_CNT_LAST) begin
                    next_s.out.load = 1'b1;
                    next_s.out.data = {s.shift[6:0], rx_i.value};
                    next_s.out.all_valid = 1'b1;
                    next_s.count = 4'h0;
                    // keeps a later partial byte right aligned
                    next_s.shift = 8'h00;
                end
            end else if (s.seen) begin
                next_s.gap = s.gap + 4'h1;
                // gap exceeds length; zero ends at first empty bit
                if (s.gap == {1'b0, gap_len_i}) begin
                    next_s.out.eof = 1'b1;
                    next_s.seen = 1'b0;
                    next_s.shift = 8'h00;
                    next_s.gap = 4'h0;
                    next_s.count = 4'h0;
                    if (s.count != 4'h0) begin
                        next_s.out.load = 1'b1;
                        next_s.out.data = s.shift;
                        next_s.out.all_valid = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_o = s.out;
endmodule

// *** rba_monitor.sv ***
// rba_monitor: bus and pin checks beside rba_top
// assumes one clock domain and a synchronous high reset
`timescale 1ns/10ps
module rba_monitor
    import rba_pkg::*;
#(
    parameter int ADR_W = 8
) (
    input wire logic mclk_i, // clock
    input wire logic reset_i, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [ADR_W-1:0] wb_adr_i, // address
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic rx_enable_i, // receive on
    input wire logic bit_tick_i, // bit time
    input rba_pkg::rba_rx_bit_t rx_a_i, // channel a bit
    input wire logic tx_byte_valid_o, // tx pulse
    input wire logic serial_data_valid_pin_o // serial valid
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_read(ix);
        s_take ##0 (!wb_we_i && wb_adr_i[7:2] == ix);
    endsequence
    chk_ack_next: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_ctl_resv: assert property (
        s_read(RBA_IDX_CTL) |=> wb_dat_o[7:4] == 4'h0)
        else $error("reserved control bits read back set");
    chk_unmapped_zero: assert property (s_read(6'h00) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_serial_cause: assert property (
        serial_data_valid_pin_o |->
        $past(bit_tick_i && rx_a_i.valid && rx_enable_i))
        else $error("serial valid without valid bit");
    chk_serial_pulse: assert property (
        serial_data_valid_pin_o |=> !serial_data_valid_pin_o)
        else $error("serial valid too long");
    chk_tx_pulse: assert property (
        tx_byte_valid_o |=> !tx_byte_valid_o)
        else $error("tx valid too long");
endmodule
bind rba_top rba_monitor #(.ADR_W(ADR_W)) mon (.mclk_i(mclk_i),
    .reset_i(reset_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_enable_i(rx_enable_i),
    .bit_tick_i(bit_tick_i), .rx_a_i(rx_a_i),
    .tx_byte_valid_o(tx_byte_valid_o),
    .serial_data_valid_pin_o(serial_data_valid_pin_o));

// *** rba_bit_source.sv ***
// rba_bit_source: correlator side, one bit per bit time, then empty bits
// assumes send_i is a one-cycle pulse
`timescale 1ns/10ps
module rba_bit_source #(
    parameter int DIV = 4
) (
    input wire logic mclk_i, // clock
    input wire logic send_i, // start a burst
    input wire logic [7:0] pat_i, // bits, highest first
    input wire logic [3:0] len_i, // valid bits in burst
    output logic bit_tick_o, // bit time pulse
    output rba_pkg::rba_rx_bit_t rx_o // bit and valid
);
    int div = 0;
    int left = 0;
    logic [7:0] pat = 8'h00;
    initial bit_tick_o = 1'b0;
    initial rx_o = '0;
    always @(posedge mclk_i) begin
        bit_tick_o <= (div == DIV - 1);
        div <= (div == DIV - 1) ? 0 : div + 1;
        if (send_i) begin
            pat <= pat_i;
            left <= len_i;
        end else if (div == DIV - 1) begin
            rx_o.valid <= left != 0;
            // empty bit times carry a changing value
            rx_o.value <= (left != 0) ? pat[left-1] : ~rx_o.value;
            if (left != 0) begin
                left <= left - 1;
            end
        end
    end
endmodule

// *** rx_byte_assembler_irq_enable_bench.sv ***
// bench for rba_top: host over wishbone, one bit source on both channels
// assumes rba_bit_source as the correlator side
`timescale 1ns/10ps
module rx_byte_assembler_irq_enable_bench;
    import rba_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rx_en = 1'b0, send = 1'b0;
    logic [7:0] adr = 8'h00, pat = 8'h00, q, p, txb;
    logic [31:0] wdat = 32'h0, rdat;
    logic [31:0] seed = 32'h1589e;
    logic [3:0] len = 4'h0, sel = 4'hf;
    logic [7:0] sbits = 8'h00;
    int s_n = 0;
    int tx_n = 0;
    logic ack, txv, sd, sdv, irq, tick;
    rba_rx_bit_t rx;
    int bad_count = 0;
    int checks_done = 0;
    always #2 mclk_i = ~mclk_i;
    rba_top DUT (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_enable_i(rx_en), .bit_tick_i(tick), .rx_a_i(rx), .rx_b_i(rx),
        .tx_byte_o(txb), .tx_byte_valid_o(txv), .serial_data_pin_o(sd),
        .serial_data_valid_pin_o(sdv), .irq_o(irq));
    rba_bit_source src (.mclk_i(mclk_i), .send_i(send), .pat_i(pat),
        .len_i(len), .bit_tick_o(tick), .rx_o(rx));
    // host view of the bit-serial pins and the tx strobe
    always @(posedge mclk_i) begin
        if (sdv) begin
            sbits <= {sbits[6:0], sd};
            s_n <= s_n + 1;
        end
        if (txv) begin
            tx_n <= tx_n + 1;
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h, want %h", $time, g, e);
        end
    endtask
    task automatic chk_irq(input logic e);
        @(negedge mclk_i);
        chk({7'h0, irq}, {7'h0, e});
    endtask
    task automatic wb(input logic w, input logic [5:0] ix,
                      input logic [7:0] d);
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        wdat <= {24'h0, d};
        do @(posedge mclk_i); while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] ix, input logic [7:0] e);
        wb(1'b0, ix, 8'h00);
        chk(q, e);
    endtask
    task automatic rx_byte(input logic [3:0] n);
        p = 8'(xs());
        pat <= p;
        len <= n;
        send <= 1'b1;
        @(posedge mclk_i);
        send <= 1'b0;
        repeat (4 * (n + 5) + 4) @(posedge mclk_i);
    endtask
    initial begin
        repeat (4000) @(posedge mclk_i);
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(RBA_IDX_CTL, RBA_CTL_RESET);
        rd(RBA_IDX_EN, RBA_EN_RESET);
        wb(1'b1, RBA_IDX_CTL, 8'h08);
        rd(RBA_IDX_CTL, 8'h08);
        rd(6'h00, 8'h00);
        wb(1'b1, RBA_IDX_EN, 8'hff);
        rd(RBA_IDX_EN, 8'hff);
        sel <= 4'he;
        wb(1'b1, RBA_IDX_EN, 8'h55);
        sel <= 4'hf;
        rd(RBA_IDX_EN, 8'hff);
        rx_en <= 1'b1;
        rx_byte(4'h8);
        chk_irq(1'b1);
        rd(RBA_IDX_STAT, 8'hbb);
        chk_irq(1'b0);
        rd(RBA_IDX_DATA_A, p);
        rd(RBA_IDX_DATA_B, p);
        wb(1'b0, RBA_IDX_DATA_A, 8'h00);
        chk_irq(1'b1);
        wb(1'b0, RBA_IDX_STAT, 8'h00);
        chk(q & 8'h77, 8'h04);
        rx_byte(4'h8);
        rx_byte(4'h8);
        wb(1'b0, RBA_IDX_STAT, 8'h00);
        chk(q & 8'h77, 8'h77);
        rd(RBA_IDX_DATA_A, p);
        rd(RBA_IDX_DATA_B, p);
        wb(1'b1, RBA_IDX_EN, 8'h00);
        wb(1'b1, RBA_IDX_CTL, 8'h0a);
        rx_byte(4'h3);
        chk_irq(1'b0);
        wb(1'b1, RBA_IDX_EN, 8'h22);
        chk_irq(1'b1);
        wb(1'b0, RBA_IDX_STAT, 8'h00);
        chk(q & 8'h77, 8'h33);
        rd(RBA_IDX_DATA_A, p & 8'h07);
        wb(1'b1, RBA_IDX_CTL, 8'h03);
        rx_byte(4'h8);
        wb(1'b0, RBA_IDX_STAT, 8'h00);
        chk(q & 8'h77, 8'h00);
        chk(sbits, p);
        chk(8'(s_n), 8'h08);
        wb(1'b1, RBA_IDX_TX, 8'ha5);
        @(negedge mclk_i);
        chk(txb, 8'h00);
        chk(8'(tx_n), 8'h00);
        wb(1'b1, RBA_IDX_CTL, 8'h08);
        wb(1'b1, RBA_IDX_TX, 8'h5a);
        @(negedge mclk_i);
        chk(txb, 8'h5a);
        chk(8'(tx_n), 8'h01);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd(RBA_IDX_CTL, RBA_CTL_RESET);
        chk(txb, 8'h00);
        complete_run();
    end
endmodule
